// ==== rtl/queue_regs_defs.svh ====
`ifndef QUEUE_REGS_DEFS_SVH
`define QUEUE_REGS_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_RX_QUEUE_BASE_CH0   8'h14
`define OFS_RX_QUEUE_BASE_CH1   8'h18
`define OFS_RX_QUEUE_BASE_CH2   8'h1c
`define OFS_RX_QUEUE_BASE_CH3   8'h20
`define OFS_TX_QUEUE_BASE_CH0   8'h24
`define OFS_TX_QUEUE_BASE_CH1   8'h28
`define OFS_TX_QUEUE_BASE_CH2   8'h2c
`define OFS_TX_QUEUE_BASE_CH3   8'h30
`define OFS_CONFIG_QUEUE_BASE   8'h3c

// ----------------------------------------------------------------
// fields, reset values and queue geometry
// ----------------------------------------------------------------
`define QUEUE_BASE_RESET        32'h0000_0000
`define QUEUE_BASE_FIXED_MASK   32'hffff_fffc
`define UNMAPPED_READ_VALUE     32'h0000_0000
`define QUEUE_DWORDS_PER_UNIT   32'h0000_0020
`define DWORD_BYTES             32'h0000_0004
`define QUEUE_REG_COUNT         9

`endif

// ==== rtl/queue_regs_pkg.sv ====
package queue_regs_pkg;

    // ----------------------------------------------------------------
    // register slots in decode order
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SLOT_RX0  = 4'h0,
        SLOT_RX1  = 4'h1,
        SLOT_RX2  = 4'h2,
        SLOT_RX3  = 4'h3,
        SLOT_TX0  = 4'h4,
        SLOT_TX1  = 4'h5,
        SLOT_TX2  = 4'h6,
        SLOT_TX3  = 4'h7,
        SLOT_CFG  = 4'h8,
        SLOT_NONE = 4'hf
    } reg_slot_t;

    // ----------------------------------------------------------------
    // one queue as seen by the dma logic
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] last;
    } queue_window_t;

endpackage

// ==== rtl/queue_base_word.sv ====
`include "queue_regs_defs.svh"

// one read/write base address word with byte lanes
module queue_base_word (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire logic [3:0]  byte_en,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] value
);

    logic [31:0] value_reg;

    // ----------------------------------------------------------------
    // storage: only software writes change it, low two bits stay zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            value_reg <= `QUEUE_BASE_RESET;
        end else if (wr_en) begin
            for (int i = 0; i < 4; i++) begin
                if (byte_en[i]) begin
                    value_reg[i*8 +: 8] <= wr_data[i*8 +: 8];
                end
            end
            value_reg[1:0] <= 2'h0; // RQ6
        end
    end

    assign value = value_reg & `QUEUE_BASE_FIXED_MASK; // RQ6

endmodule

// ==== rtl/interrupt_queue_base_regs.sv ====
`include "queue_regs_defs.svh"

// How it works
// (RQ1) four rx queue base words, channels 0..3, at 0x14 to 0x20
// (RQ2) four tx queue base words, channels 0..3, at 0x24 to 0x30
// (RQ3) one config queue base word at 0x3c locates that queue
// (RQ4) base bits 31..2 reach anywhere in the 32-bit address space
// (RQ5) software places every queue base on a four-byte boundary
// (RQ6) bits 1..0 written as zero, always treated as zero here
// (RQ7) queue spans (1 + length) times 32 dwords from its base
// (RQ8) bases reset to zero and change only by software writes
module interrupt_queue_base_regs #(
    parameter int LEN_W = 4
) (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic [7:0]                            address,
    input  wire logic                                  read,
    input  wire logic                                  write,
    input  wire logic [31:0]                           writedata,
    input  wire logic [3:0]                            byteenable,
    output logic      [31:0]                           readdata,
    output logic                                       waitrequest,
    input  wire logic [3:0][LEN_W-1:0]                 rx_queue_length,
    input  wire logic [3:0][LEN_W-1:0]                 tx_queue_length,
    input  wire logic [LEN_W-1:0]                      config_queue_length,
    output queue_regs_pkg::queue_window_t [3:0]        rx_queue_window,
    output queue_regs_pkg::queue_window_t [3:0]        tx_queue_window,
    output queue_regs_pkg::queue_window_t              config_queue_window
);

    localparam int N = `QUEUE_REG_COUNT;

    logic                      ack_reg;
    logic                      ack_next;
    logic [31:0]               readdata_reg;
    logic [31:0]               readdata_next;
    queue_regs_pkg::reg_slot_t slot;
    logic [N-1:0][31:0]        word;
    logic [N-1:0]              word_wr;
    logic [N-1:0][LEN_W-1:0]   length;
    logic [N-1:0][31:0]        last_reg;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // unlisted or unaligned offsets decode to no slot
    always_comb begin
        case (address)
            `OFS_RX_QUEUE_BASE_CH0: slot = queue_regs_pkg::SLOT_RX0; // RQ1
            `OFS_RX_QUEUE_BASE_CH1: slot = queue_regs_pkg::SLOT_RX1; // RQ1
            `OFS_RX_QUEUE_BASE_CH2: slot = queue_regs_pkg::SLOT_RX2; // RQ1
            `OFS_RX_QUEUE_BASE_CH3: slot = queue_regs_pkg::SLOT_RX3; // RQ1
            `OFS_TX_QUEUE_BASE_CH0: slot = queue_regs_pkg::SLOT_TX0; // RQ2
            `OFS_TX_QUEUE_BASE_CH1: slot = queue_regs_pkg::SLOT_TX1; // RQ2
            `OFS_TX_QUEUE_BASE_CH2: slot = queue_regs_pkg::SLOT_TX2; // RQ2
            `OFS_TX_QUEUE_BASE_CH3: slot = queue_regs_pkg::SLOT_TX3; // RQ2
            `OFS_CONFIG_QUEUE_BASE: slot = queue_regs_pkg::SLOT_CFG; // RQ3
            default:                slot = queue_regs_pkg::SLOT_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // avalon handshake: one wait cycle, answer in the second cycle
    // ----------------------------------------------------------------
    assign ack_next    = (read || write) && !ack_reg;
    assign waitrequest = (read || write) && !ack_reg;
    assign readdata    = readdata_reg;

    // acknowledge flag, dropped right after the accepting edge
    // so a held request never gets two answers in a row
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    // read data prepared in the wait cycle, stands in the answer cycle
    always_comb begin
        readdata_next = `UNMAPPED_READ_VALUE;
        if (slot != queue_regs_pkg::SLOT_NONE) begin
            readdata_next = word[slot]; // RQ6
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata_reg <= `UNMAPPED_READ_VALUE;
        end else if (read && !ack_reg) begin
            readdata_reg <= readdata_next;
        end
    end

    // ----------------------------------------------------------------
    // base address words
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_word
            // write strobe only at the edge where waitrequest is low
            assign word_wr[g] = write && ack_reg && (slot == 4'(g)); // RQ8
            queue_base_word u_word (
                .clk     (clk),
                .rst     (rst),
                .wr_en   (word_wr[g]),
                .byte_en (byteenable),
                .wr_data (writedata),
                .value   (word[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // queue windows for the dma logic
    // ----------------------------------------------------------------
    for (g = 0; g < 4; g++) begin : gen_len
        assign length[g]   = rx_queue_length[g];
        assign length[g+4] = tx_queue_length[g];
    end
    assign length[8] = config_queue_length;

    // last dword address of a queue: base + (1 + len) * 32 dwords - 1 dword
    function automatic logic [31:0] last_dword(input logic [31:0]      base,
                                               input logic [LEN_W-1:0] len);
        logic [31:0] span;
        span = (32'(len) + 32'h1) * `QUEUE_DWORDS_PER_UNIT * `DWORD_BYTES;
        return base + span - `DWORD_BYTES; // RQ7
    endfunction

    // last dword registered: the dma side sees a settled value
    // one edge after a base or length change
    always_ff @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            last_reg[i] <= last_dword(word[i], length[i]); // RQ7
        end
    end

    // windows: base straight from storage, last from its register
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rx_queue_window[i].base = word[i];             // RQ1 RQ4
            rx_queue_window[i].last = last_reg[i];
            tx_queue_window[i].base = word[i+4];           // RQ2 RQ4
            tx_queue_window[i].last = last_reg[i+4];
        end
        config_queue_window.base = word[8];                // RQ3
        config_queue_window.last = last_reg[8];
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // full-word write at the edge where waitrequest is low
    sequence write_taken(logic [7:0] ofs);
        write && !waitrequest && address == ofs && byteenable == 4'hf;
    endsequence

    // read answered: read data stands at this edge
    sequence read_taken;
        read && !waitrequest;
    endsequence

    AST_RX0_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ1
        write_taken(`OFS_RX_QUEUE_BASE_CH0)
        |=> rx_queue_window[0].base == ($past(writedata) & `QUEUE_BASE_FIXED_MASK))
        else $error("rx channel 0 base not written");

    AST_TX3_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ2
        write_taken(`OFS_TX_QUEUE_BASE_CH3)
        |=> tx_queue_window[3].base == ($past(writedata) & `QUEUE_BASE_FIXED_MASK))
        else $error("tx channel 3 base not written");

    AST_CFG_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ3
        write_taken(`OFS_CONFIG_QUEUE_BASE)
        |=> config_queue_window.base == ($past(writedata) & `QUEUE_BASE_FIXED_MASK))
        else $error("config base not written");

    AST_READBACK: assert property (@(posedge clk) disable iff (rst) // RQ4
        (read && waitrequest && slot == queue_regs_pkg::SLOT_TX1)
        ##1 read_taken |-> readdata == tx_queue_window[1].base)
        else $error("tx channel 1 base read back wrong");

    AST_LOW_BITS_ZERO: assert property (@(posedge clk) disable iff (rst) // RQ6
        read_taken |-> readdata[1:0] == 2'h0)
        else $error("base bits 1..0 read nonzero");

    AST_SPAN: assert property (@(posedge clk) disable iff (rst) // RQ7
        rx_queue_window[2].last == $past(rx_queue_window[2].base)
        + (32'($past(rx_queue_length[2])) + 32'h1) * 32'h80 - 32'h4)
        else $error("rx channel 2 queue span wrong");

    AST_CFG_SPAN: assert property (@(posedge clk) disable iff (rst) // RQ7
        config_queue_window.last == $past(config_queue_window.base)
        + (32'($past(config_queue_length)) + 32'h1) * 32'h80 - 32'h4)
        else $error("config queue span wrong");

    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (rst) // RQ1
        (read && waitrequest && slot == queue_regs_pkg::SLOT_NONE)
        ##1 read_taken |-> readdata == `UNMAPPED_READ_VALUE)
        else $error("unmapped offset read nonzero");

    AST_NO_EARLY_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ8
        write && waitrequest |=> $stable(config_queue_window.base))
        else $error("config base written during the wait cycle");

    AST_STABLE: assert property (@(posedge clk) disable iff (rst) // RQ8
        !(write && !waitrequest) |=> $stable(config_queue_window.base))
        else $error("config base changed without a write");

    AST_RESET_ZERO: assert property (@(posedge clk) // RQ8
        $past(rst) |-> rx_queue_window[3].base == 32'h0 && tx_queue_window[0].base == 32'h0)
        else $error("base not zero after reset");

    AST_ONE_WAIT: assert property (@(posedge clk) disable iff (rst)
        (read || write) && waitrequest ##1 (read || write) |-> !waitrequest)
        else $error("request waited more than one cycle");

    AST_FIRST_WAIT: assert property (@(posedge clk) disable iff (rst)
        !(read || write) ##1 (read || write) |-> waitrequest)
        else $error("fresh request answered without a wait cycle");

endmodule

// ==== verification/host_cpu_model.sv ====
// host cpu: avalon master that programs the queue base words
module host_cpu_model (
    input  wire logic        clk,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    output logic      [7:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus from time zero
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
    end

    // request held until waitrequest is sampled low; only the bench watchdog ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // software clears bits 1..0 unless asked to misbehave
    task automatic write_word(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                              input logic aligned);
        logic [31:0] q;
        xfer(1'b1, a, aligned ? (d & 32'hffff_fffc) : d, be, q);
    endtask

    task automatic read_word(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
    endtask
endmodule

// ==== verification/interrupt_queue_base_regs_bench.sv ====
module interrupt_queue_base_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] holes [5] = '{8'h10, 8'h34, 8'h38, 8'h40, 8'h16};
    logic                                clk;
    logic                                rst;
    logic [7:0]                          address;
    logic                                read;
    logic                                write;
    logic [31:0]                         writedata;
    logic [3:0]                          byteenable;
    logic [31:0]                         readdata;
    logic                                waitrequest;
    logic [3:0][3:0]                     rx_len;
    logic [3:0][3:0]                     tx_len;
    logic [3:0]                          cfg_len;
    queue_regs_pkg::queue_window_t [3:0] rx_win;
    queue_regs_pkg::queue_window_t [3:0] tx_win;
    queue_regs_pkg::queue_window_t       cfg_win;
    logic [31:0]                         model_q [9];
    logic [3:0]                          len_q [9];
    logic [31:0]                         seed;
    int                                  miscompares;
    int                                  checked;

    interrupt_queue_base_regs dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .rx_queue_length(rx_len), .tx_queue_length(tx_len),
        .config_queue_length(cfg_len), .rx_queue_window(rx_win), .tx_queue_window(tx_win),
        .config_queue_window(cfg_win));
    host_cpu_model host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable));

    // clock and length inputs
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            rx_len[i] <= len_q[i];
            tx_len[i] <= len_q[i + 4];
        end
        cfg_len <= len_q[8];
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] ofs(input int i);
        return (i < 8) ? 8'(8'h14 + 4 * i) : 8'h3c;
    endfunction
    function automatic queue_regs_pkg::queue_window_t win(input int i);
        if (i < 4) return rx_win[i];
        if (i < 8) return tx_win[i - 4];
        return cfg_win;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // windows and read-back of every slot against the model
    task automatic check_all();
        logic [31:0]                   q;
        queue_regs_pkg::queue_window_t w;
        @(posedge clk);
        #1;
        for (int i = 0; i < 9; i++) begin
            w = win(i);
            check(w.base, model_q[i]);
            check(w.last, model_q[i] + (32'h1 + len_q[i]) * 32'h80 - 32'h4);
            host.read_word(ofs(i), q);
            check(q, model_q[i]);
        end
    endtask

    // model keeps written lanes, low two bits always zero
    task automatic write_slot(input int i, input logic [31:0] d, input logic [3:0] be,
                              input logic aligned);
        host.write_word(ofs(i), d, be, aligned);
        for (int b = 0; b < 4; b++) if (be[b]) model_q[i][b*8 +: 8] = d[b*8 +: 8];
        model_q[i][1:0] = 2'b00;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #(25 * 20000);
        miscompares++;
        stop_test();
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        logic [31:0] x;
        logic [31:0] q;
        clk = 1'b0;
        rst = 1'b1;
        seed = 32'h0000_c754;
        miscompares = 0;
        checked = 0;
        rx_len = '0;
        tx_len = '0;
        cfg_len = 4'h0;
        for (int i = 0; i < 9; i++) begin
            model_q[i] = 32'h0000_0000;
            len_q[i] = 4'h0;
        end
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        check_all();
        // lengths 0, random, random, 15; partial lanes; unaligned low bits
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 9; i++) begin
                x = rnd();
                len_q[i] <= (r == 0) ? 4'h0 : (r == 3) ? 4'hf : x[3:0];
                x = rnd();
                write_slot(i, x, (r == 1) ? x[7:4] : 4'hf, r != 2);
            end
            check_all();
        end
        // holes read zero and ignore writes
        for (int k = 0; k < 5; k++) begin
            host.read_word(holes[k], q);
            check(q, 32'h0000_0000);
            host.write_word(holes[k], rnd(), 4'hf, 1'b0);
        end
        check_all();
        // reset in mid-run clears every base
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) model_q[i] = 32'h0000_0000;
        check_all();
        stop_test();
    end
endmodule
